// ==== design/read_multiple_ext_cmd.v ====
// Device-side 48-bit multi-sector PIO read command with Avalon-MM register access
//
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "read_multiple_ext_consts.vh"

module read_multiple_ext_cmd #(
  parameter PACKET_SET = 0
) (
  input  wire        core_clk,
  input  wire        nrst,
  input  wire [7:0]  avAddress,
  input  wire        avRead,
  input  wire        avWrite,
  input  wire [31:0] avWritedata,
  input  wire [3:0]  avByteenable,
  output reg  [31:0] avReaddata,
  output wire        avWaitrequest,
  output wire        irq,
  output reg         hostIntLine,
  input  wire [15:0] mediaData,
  input  wire        mediaValid,
  output wire        mediaReady,
  output reg         mediaStart,
  output reg  [47:0] mediaLba,
  output reg  [16:0] mediaSectors,
  output reg         mediaDevice
);

  // One-hot sequencer: idle, block setup, word transfer
  localparam S_IDLE = 3'b001;
  localparam S_PREP = 3'b010;
  localparam S_XFER = 3'b100;

  // Readback byte chooser for the two-deep taskfile
  function [7:0] pickByte;
    input [7:0] cur;
    input [7:0] prev;
    input       high_byte_readback_select;
    begin
      pickByte = high_byte_readback_select ? prev : cur;
    end
  endfunction

  // Sectors in the next block: a full block or the remainder
  function [16:0] blockLen;
    input [16:0] remaining;
    input [7:0]  perBlock;
    begin
      if (remaining > {9'h000, perBlock}) begin
        blockLen = {9'h000, perBlock};
      end else begin
        blockLen = remaining;
      end
    end
  endfunction

  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [7:0]  featCur_q;
  reg  [7:0]  featPrev_q;
  reg  [7:0]  cntCur_q;
  reg  [7:0]  cntPrev_q;
  reg  [7:0]  a0Cur_q;
  reg  [7:0]  a0Prev_q;
  reg  [7:0]  a1Cur_q;
  reg  [7:0]  a1Prev_q;
  reg  [7:0]  a2Cur_q;
  reg  [7:0]  a2Prev_q;
  reg  [7:0]  driveSel_q;
  reg  [7:0]  devCtl_q;
  reg  [8:0]  multiCfg_q;
  reg  [7:0]  failure_q;
  reg         busy_q;
  reg         ready_q;
  reg         fault_q;
  reg         dreq_q;
  reg         err_q;
  reg  [16:0] remaining_q;
  reg  [16:0] blockLeft_q;
  reg  [8:0]  wordCnt_q;
  reg  [2:0]  irqStatus_q;
  reg  [2:0]  irqMask_q;
  reg         rdAck_q;

  wire        wrLow = avWrite & avByteenable[0];
  wire        wrHigh = avWrite & avByteenable[1];
  wire        selData = (avAddress == `OFS_DATA);
  wire        high_byte_readback_select = devCtl_q[`DCTL_HOB_BIT];
  wire        inXfer = (state_q == S_XFER);
  // Data reads stall until the media side has a word, so no word is invented
  wire        canAnswer = ~(selData & inXfer & ~mediaValid);
  wire        rdTake = avRead & ~rdAck_q & canAnswer;
  wire        popWord = rdTake & selData & inXfer;
  wire        tfWrite = wrLow & ~busy_q & ~dreq_q;
  wire        cmdWrite = tfWrite & (avAddress == `OFS_OPCODE);
  wire        isOpcode = (avWritedata[7:0] == `OPCODE_READ_MULTI_EXT);
  wire        multiOn = multiCfg_q[`MCFG_ENABLE_BIT] & (multiCfg_q[7:0] != 8'h00);
  wire        lbaMode = driveSel_q[`DSEL_LBA_BIT];
  wire        cmdAccept;
  wire        cmdReject;
  wire        sectorEnd = popWord & (wordCnt_q == (`SECTOR_WORDS - 9'h001));
  wire        blockEnd = sectorEnd & (blockLeft_q == 17'h00001);
  wire        lastBlock = blockEnd & (remaining_q == 17'h00001);
  wire [16:0] countFull;
  wire [2:0]  irqEvents;
  wire [7:0]  condition;

  // Packet devices and disabled multiple mode refuse; host must pick LINEAR_BLOCK_ADDRESSING mode
  assign cmdAccept = cmdWrite & isOpcode & (PACKET_SET == 0) & multiOn & lbaMode;
  assign cmdReject = cmdWrite & ~cmdAccept;

  // Count low byte is latest write, high byte the one before; zero is maximum
  assign countFull = ({cntPrev_q, cntCur_q} == 16'h0000) ?
                     `MAX_SECTORS : {1'b0, cntPrev_q, cntCur_q};

  assign condition = {busy_q, ready_q, fault_q, 1'b0, dreq_q, 2'b00, err_q};
  // Abort, done and block-ready events in status bit order
  assign irqEvents = {cmdReject, lastBlock, (state_q == S_PREP)};
  // Writes never stall; a read waits for its registered answer
  assign avWaitrequest = avRead & ~rdAck_q;
  assign mediaReady = popWord;
  assign irq = |(irqStatus_q & irqMask_q);

  always @* begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (cmdAccept) begin
          state_d = S_PREP;
        end
      end
      S_PREP: begin
        state_d = S_XFER;
      end
      S_XFER: begin
        if (lastBlock) begin
          state_d = S_IDLE;
        end else if (blockEnd) begin
          state_d = S_PREP;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  // Two-deep taskfile; writes while busy or requesting data are ignored
  always @(posedge core_clk) begin
    if (!nrst) begin
      featCur_q  <= `RST_BYTE;
      featPrev_q <= `RST_BYTE;
      cntCur_q   <= `RST_BYTE;
      cntPrev_q  <= `RST_BYTE;
      a0Cur_q    <= `RST_BYTE;
      a0Prev_q   <= `RST_BYTE;
      a1Cur_q    <= `RST_BYTE;
      a1Prev_q   <= `RST_BYTE;
      a2Cur_q    <= `RST_BYTE;
      a2Prev_q   <= `RST_BYTE;
      driveSel_q <= `RST_BYTE;
    end else if (tfWrite) begin
      case (avAddress)
        `OFS_FEATURES: begin
          featPrev_q <= featCur_q;
          featCur_q  <= avWritedata[7:0];
        end
        `OFS_COUNT: begin
          cntPrev_q <= cntCur_q;
          cntCur_q  <= avWritedata[7:0];
        end
        `OFS_ADDR0: begin
          a0Prev_q <= a0Cur_q;
          a0Cur_q  <= avWritedata[7:0];
        end
        `OFS_ADDR1: begin
          a1Prev_q <= a1Cur_q;
          a1Cur_q  <= avWritedata[7:0];
        end
        `OFS_ADDR2: begin
          a2Prev_q <= a2Cur_q;
          a2Cur_q  <= avWritedata[7:0];
        end
        `OFS_DRIVE_SEL: begin
          driveSel_q <= avWritedata[7:0];
        end
        // Opcode and read-only offsets leave the taskfile alone
        default: begin
          driveSel_q <= driveSel_q;
        end
      endcase
    end
  end

  // Device control and interrupt mask stay writable at any time; multiple config only when not busy or requesting data
  always @(posedge core_clk) begin
    if (!nrst) begin
      devCtl_q   <= `RST_BYTE;
      multiCfg_q <= `RST_MULTI_CFG;
      irqMask_q  <= 3'h0;
    end else begin
      if (wrLow & (avAddress == `OFS_DEV_CONTROL)) begin
        devCtl_q <= avWritedata[7:0];
      end
      if (wrLow & (avAddress == `OFS_MULTI_CFG) & ~busy_q & ~dreq_q) begin
        multiCfg_q[7:0] <= avWritedata[7:0];
      end
      if (wrHigh & (avAddress == `OFS_MULTI_CFG) & ~busy_q & ~dreq_q) begin
        multiCfg_q[8] <= avWritedata[8];
      end
      if (wrLow & (avAddress == `OFS_IRQ_MASK)) begin
        irqMask_q <= avWritedata[2:0];
      end
    end
  end

  // Command sequencing, flags and media request
  always @(posedge core_clk) begin
    if (!nrst) begin
      state_q      <= S_IDLE;
      busy_q       <= 1'b0;
      ready_q      <= 1'b1;
      fault_q      <= 1'b0;
      dreq_q       <= 1'b0;
      err_q        <= 1'b0;
      failure_q    <= `RST_BYTE;
      remaining_q  <= 17'h00000;
      blockLeft_q  <= 17'h00000;
      wordCnt_q    <= 9'h000;
      mediaStart   <= 1'b0;
      mediaLba     <= 48'h000000000000;
      mediaSectors <= 17'h00000;
      mediaDevice  <= 1'b0;
    end else begin
      state_q    <= state_d;
      mediaStart <= 1'b0;
      if (cmdAccept) begin
        busy_q      <= 1'b1;
        err_q       <= 1'b0;
        fault_q     <= 1'b0;
        failure_q   <= `RST_BYTE;
        remaining_q <= countFull;
        mediaStart  <= 1'b1;
        mediaSectors <= countFull;
        mediaLba    <= {a2Prev_q, a1Prev_q, a0Prev_q, a2Cur_q, a1Cur_q, a0Cur_q};
        mediaDevice <= driveSel_q[`DSEL_DEV_BIT];
      end else if (cmdReject) begin
        busy_q    <= 1'b0;
        ready_q   <= 1'b1;
        dreq_q    <= 1'b0;
        err_q     <= 1'b1;
        failure_q <= 8'h01 << `FAIL_ABORT_BIT;
      end
      if (state_q == S_PREP) begin
        // Busy drops and request rises only here, once per block
        busy_q      <= 1'b0;
        dreq_q      <= 1'b1;
        blockLeft_q <= blockLen(remaining_q, multiCfg_q[7:0]);
        wordCnt_q   <= 9'h000;
      end
      if (popWord) begin
        wordCnt_q <= sectorEnd ? 9'h000 : (wordCnt_q + 9'h001);
      end
      if (sectorEnd) begin
        remaining_q <= remaining_q - 17'h00001;
        blockLeft_q <= blockLeft_q - 17'h00001;
      end
      if (lastBlock) begin
        busy_q  <= 1'b0;
        ready_q <= 1'b1;
        dreq_q  <= 1'b0;
        fault_q <= 1'b0;
        err_q   <= 1'b0;
      end else if (blockEnd) begin
        // Between blocks the device is busy fetching the next one
        busy_q <= 1'b1;
        dreq_q <= 1'b0;
      end
    end
  end

  // Pending line: set at each block start or abort, cleared by reading condition
  always @(posedge core_clk) begin
    if (!nrst) begin
      hostIntLine <= 1'b0;
    end else if ((state_q == S_PREP) | cmdReject) begin
      hostIntLine <= 1'b1;
    end else if (rdTake & (avAddress == `OFS_CONDITION)) begin
      hostIntLine <= 1'b0;
    end
  end

  // Sticky events; a new event outruns a same-cycle clear
  always @(posedge core_clk) begin
    if (!nrst) begin
      irqStatus_q <= 3'h0;
    end else if (wrLow & (avAddress == `OFS_IRQ_STATUS)) begin
      irqStatus_q <= (irqStatus_q & ~avWritedata[2:0]) | irqEvents;
    end else begin
      irqStatus_q <= irqStatus_q | irqEvents;
    end
  end

  // Reads answer one cycle after the request, later if data must wait
  always @(posedge core_clk) begin
    if (!nrst) begin
      rdAck_q    <= 1'b0;
      avReaddata <= 32'h00000000;
    end else begin
      rdAck_q <= rdTake;
      if (rdTake) begin
        case (avAddress)
          `OFS_COUNT: begin
            avReaddata <= {24'h000000, pickByte(cntCur_q, cntPrev_q, high_byte_readback_select)};
          end
          `OFS_ADDR0: begin
            avReaddata <= {24'h000000, pickByte(a0Cur_q, a0Prev_q, high_byte_readback_select)};
          end
          `OFS_ADDR1: begin
            avReaddata <= {24'h000000, pickByte(a1Cur_q, a1Prev_q, high_byte_readback_select)};
          end
          `OFS_ADDR2: begin
            avReaddata <= {24'h000000, pickByte(a2Cur_q, a2Prev_q, high_byte_readback_select)};
          end
          `OFS_DRIVE_SEL: begin
            avReaddata <= {24'h000000, driveSel_q};
          end
          `OFS_FAILURE: begin
            avReaddata <= {24'h000000, failure_q};
          end
          `OFS_CONDITION: begin
            avReaddata <= {24'h000000, condition};
          end
          `OFS_DEV_CONTROL: begin
            avReaddata <= {24'h000000, devCtl_q};
          end
          `OFS_DATA: begin
            // Outside a transfer the data port reads zero and pops nothing
            avReaddata <= inXfer ? {16'h0000, mediaData} : 32'h00000000;
          end
          `OFS_MULTI_CFG: begin
            avReaddata <= {23'h000000, multiCfg_q};
          end
          `OFS_IRQ_STATUS: begin
            avReaddata <= {29'h00000000, irqStatus_q};
          end
          `OFS_IRQ_MASK: begin
            avReaddata <= {29'h00000000, irqMask_q};
          end
          default: begin
            avReaddata <= 32'h00000000;
          end
        endcase
      end
    end
  end

endmodule

// ==== design/read_multiple_ext_consts.vh ====
// Constants for the 48-bit multi-sector PIO read command block
`ifndef READ_MULTIPLE_EXT_CONSTS_VH
`define READ_MULTIPLE_EXT_CONSTS_VH

// Register byte offsets on the Avalon slave
`define OFS_FEATURES      8'h00
`define OFS_COUNT         8'h04
`define OFS_ADDR0         8'h08
`define OFS_ADDR1         8'h0C
`define OFS_ADDR2         8'h10
`define OFS_DRIVE_SEL     8'h14
`define OFS_OPCODE        8'h18
`define OFS_FAILURE       8'h1C
`define OFS_CONDITION     8'h20
`define OFS_DEV_CONTROL   8'h24
`define OFS_DATA          8'h28
`define OFS_MULTI_CFG     8'h2C
`define OFS_IRQ_STATUS    8'h30
`define OFS_IRQ_MASK      8'h34

// Command code
`define OPCODE_READ_MULTI_EXT 8'h29

// Unit condition bit positions
`define COND_BUSY_BIT     7
`define COND_READY_BIT    6
`define COND_FAULT_BIT    5
`define COND_DREQ_BIT     3
`define COND_ERR_BIT      0

// Failure detail bit positions
`define FAIL_ABORT_BIT    2

// Drive select register fields
`define DSEL_LBA_BIT      6
`define DSEL_DEV_BIT      4

// Device control and multiple configuration fields
`define DCTL_HOB_BIT      7
`define MCFG_ENABLE_BIT   8

// Interrupt status bit positions
`define IRQ_BLOCK_BIT     0
`define IRQ_DONE_BIT      1
`define IRQ_ABORT_BIT     2

// Reset values
`define RST_CONDITION     8'h40
`define RST_MULTI_CFG     9'h010
`define RST_BYTE          8'h00

// Sector geometry and the zero-count meaning
`define SECTOR_WORDS      9'h100
`define MAX_SECTORS       17'h10000

`endif

// ==== sim/media_model.sv ====
// Media-side word source that stalls now and then
`timescale 1ns/10ps
module media_model #(
  parameter SLOW = 1
) (
  input  wire        core_clk,
  input  wire        nrst,
  input  wire        mediaReady,
  output wire [15:0] mediaData,
  output wire        mediaValid
);
  reg [15:0] word_q;
  reg [1:0]  pace_q;
  // One cycle in four not ready, to exercise the stall path
  assign mediaValid = !SLOW || pace_q != 2'h3;
  // Idle bus shows the inverse so stale words cannot pass
  assign mediaData = mediaValid ? word_q : ~word_q;
  always @(posedge core_clk) begin
    if (!nrst) begin
      word_q <= 16'h0000;
      pace_q <= 2'h0;
    end else begin
      pace_q <= pace_q + 2'h1;
      if (mediaReady)
        word_q <= word_q + 16'h0001;
    end
  end
endmodule

// ==== sim/read_multiple_ext_cmd_chk.sv ====
// Port assertions for the multi-sector read command block
`timescale 1ns/10ps
`include "read_multiple_ext_consts.vh"
module read_multiple_ext_cmd_chk (
  input wire        core_clk,
  input wire        nrst,
  input wire [7:0]  avAddress,
  input wire        avRead,
  input wire        avWrite,
  input wire [31:0] avWritedata,
  input wire        avWaitrequest,
  input wire        hostIntLine,
  input wire        mediaValid,
  input wire        mediaReady,
  input wire        mediaStart,
  input wire [16:0] mediaSectors
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  AST_WR_NOWAIT: assert property (avWrite |-> !avWaitrequest)
    else $error("write was stalled");
  AST_IDLE_NOWAIT: assert property (!avRead |-> !avWaitrequest)
    else $error("wait without a read");
  AST_RD_LAT: assert property (avRead && avWaitrequest && avAddress != `OFS_DATA
    |=> !avWaitrequest) else $error("register read took too long");
  AST_START_CAUSE: assert property (mediaStart |-> $past(avWrite &&
    avAddress == `OFS_OPCODE && avWritedata[7:0] == `OPCODE_READ_MULTI_EXT))
    else $error("start without the read opcode");
  AST_START_PULSE: assert property (mediaStart |=> !mediaStart)
    else $error("start longer than one cycle");
  AST_START_INT: assert property (mediaStart |=> hostIntLine)
    else $error("no interrupt before first block");
  AST_SECT_RANGE: assert property (mediaStart |-> mediaSectors != 17'h00000
    && mediaSectors <= `MAX_SECTORS) else $error("sector count out of range");
  AST_POP: assert property (mediaReady |-> mediaValid && avRead
    && avAddress == `OFS_DATA) else $error("word taken without a data read");
endmodule
bind read_multiple_ext_cmd read_multiple_ext_cmd_chk chk (
  .core_clk     (core_clk),
  .nrst         (nrst),
  .avAddress    (avAddress),
  .avRead       (avRead),
  .avWrite      (avWrite),
  .avWritedata  (avWritedata),
  .avWaitrequest(avWaitrequest),
  .hostIntLine  (hostIntLine),
  .mediaValid   (mediaValid),
  .mediaReady   (mediaReady),
  .mediaStart   (mediaStart),
  .mediaSectors (mediaSectors)
);

// ==== sim/tb_top.sv ====
// Self-checking bench for the multi-sector read command block
`timescale 1ns/10ps
`include "read_multiple_ext_consts.vh"
`define CHK(n, e, g) begin nChecks++; if ((g) !== (e)) begin errTotal++; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module tb_top;
  reg         core_clk = 1'b0;
  reg         nrst = 1'b0;
  reg  [7:0]  avAddress = 8'h00;
  reg         avRead = 1'b0;
  reg         avWrite = 1'b0;
  reg  [31:0] avWritedata = 32'h00000000;
  reg  [31:0] rd;
  reg  [15:0] expWord = 16'h0000;
  wire [31:0] avReaddata;
  wire        avWaitrequest, irq, hostIntLine, mediaValid, mediaReady, mediaStart;
  wire        mediaDevice;
  wire [15:0] mediaData;
  wire [47:0] mediaLba;
  wire [16:0] mediaSectors;
  integer     errTotal = 0, nChecks = 0, cyc = 0, i, k;
  // Address, previous byte, current byte; also the command parameters
  reg  [23:0] rows [0:3] = '{{`OFS_COUNT, 16'h0003}, {`OFS_ADDR0, 16'hA1B2},
                             {`OFS_ADDR1, 16'hC3D4}, {`OFS_ADDR2, 16'hE5F6}};

  read_multiple_ext_cmd dut (
    .core_clk(core_clk), .nrst(nrst), .avAddress(avAddress), .avRead(avRead),
    .avWrite(avWrite), .avWritedata(avWritedata), .avByteenable(4'hF),
    .avReaddata(avReaddata), .avWaitrequest(avWaitrequest), .irq(irq),
    .hostIntLine(hostIntLine), .mediaData(mediaData), .mediaValid(mediaValid),
    .mediaReady(mediaReady), .mediaStart(mediaStart), .mediaLba(mediaLba),
    .mediaSectors(mediaSectors), .mediaDevice(mediaDevice));
  media_model media (.core_clk(core_clk), .nrst(nrst), .mediaReady(mediaReady),
    .mediaData(mediaData), .mediaValid(mediaValid));

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  task stopTest;
    begin
      $display("checks %0d errors %0d", nChecks, errTotal);
      if (errTotal == 0 && nChecks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errTotal++;
      stopTest;
    end
  end

  task wr(input [7:0] a, input [31:0] d);
    begin
      avAddress <= a;
      avWritedata <= d;
      avWrite <= 1'b1;
      do @(posedge core_clk); while (avWaitrequest !== 1'b0);
      avWrite <= 1'b0;
      @(posedge core_clk);
    end
  endtask

  task rdr(input [7:0] a);
    begin
      avAddress <= a;
      avRead <= 1'b1;
      do @(posedge core_clk); while (avWaitrequest !== 1'b0);
      rd = avReaddata;
      avRead <= 1'b0;
      @(posedge core_clk);
    end
  endtask

  task rc(input [7:0] a, input [31:0] e);
    begin
      rdr(a);
      `CHK($sformatf("reg %0h", a), e, rd)
    end
  endtask

  // Bounded wait for the host interrupt line
  task waitInt;
    repeat (200) if (hostIntLine !== 1'b1) @(posedge core_clk);
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rc(`OFS_CONDITION, 32'h40);
    rc(`OFS_MULTI_CFG, 32'h010);
    rc(`OFS_IRQ_MASK, 32'h0);
    rc(8'h3C, 32'h0);
    for (i = 0; i < 4; i++) begin
      wr(rows[i][23:16], {24'h0, rows[i][15:8]});
      wr(rows[i][23:16], {24'h0, rows[i][7:0]});
      wr(`OFS_DEV_CONTROL, 32'h00);
      rc(rows[i][23:16], {24'h0, rows[i][7:0]});
      wr(`OFS_DEV_CONTROL, 32'h80);
      rc(rows[i][23:16], {24'h0, rows[i][15:8]});
    end
    // Multiple reads still disabled from reset
    wr(`OFS_DRIVE_SEL, 32'h50);
    wr(`OFS_OPCODE, 32'h29);
    waitInt;
    rc(`OFS_FAILURE, 32'h04);
    rc(`OFS_CONDITION, 32'h41);
    rc(`OFS_IRQ_STATUS, 32'h4);
    wr(`OFS_IRQ_STATUS, 32'h7);
    // Three sectors in blocks of two leave a partial block of one
    wr(`OFS_MULTI_CFG, 32'h102);
    wr(`OFS_IRQ_MASK, 32'h7);
    wr(`OFS_OPCODE, 32'h29);
    for (k = 0; k < 2; k++) begin
      waitInt;
      `CHK("lba", 48'hE5C3A1F6D4B2, mediaLba)
      `CHK("sectors", 17'h00003, mediaSectors)
      `CHK("device", 1'b1, mediaDevice)
      `CHK("irq", 1'b1, irq)
      rc(`OFS_CONDITION, 32'h48);
      wr(`OFS_IRQ_STATUS, 32'h1);
      `CHK("irq", 1'b0, irq)
      wr(`OFS_COUNT, 32'h77);
      for (i = 0; i < (k == 0 ? 512 : 256); i++) begin
        rdr(`OFS_DATA);
        `CHK("word", {16'h0, expWord}, rd)
        expWord++;
        if (i < (k == 0 ? 511 : 255))
          `CHK("int", 1'b0, hostIntLine)
      end
    end
    rc(`OFS_CONDITION, 32'h40);
    wr(`OFS_DEV_CONTROL, 32'h00);
    rc(`OFS_COUNT, 32'h03);
    rc(`OFS_IRQ_STATUS, 32'h2);
    wr(`OFS_IRQ_MASK, 32'h0);
    `CHK("irq", 1'b0, irq)
    wr(`OFS_IRQ_MASK, 32'h2);
    `CHK("irq", 1'b1, irq)
    wr(`OFS_IRQ_STATUS, 32'h2);
    `CHK("irq", 1'b0, irq)
    // LINEAR_BLOCK_ADDRESSING bit clear, then an unknown opcode: each aborts with multiple enabled
    wr(`OFS_DRIVE_SEL, 32'h10);
    wr(`OFS_OPCODE, 32'h29);
    rc(`OFS_IRQ_STATUS, 32'h4);
    rc(`OFS_CONDITION, 32'h41);
    wr(`OFS_IRQ_STATUS, 32'h4);
    wr(`OFS_DRIVE_SEL, 32'h40);
    wr(`OFS_OPCODE, 32'h20);
    rc(`OFS_IRQ_STATUS, 32'h4);
    rc(`OFS_CONDITION, 32'h41);
    // Zero count means the full 65,536; too long to run out, so reset after
    wr(`OFS_COUNT, 32'h00);
    wr(`OFS_COUNT, 32'h00);
    wr(`OFS_OPCODE, 32'h29);
    waitInt;
    `CHK("sectors", 17'h10000, mediaSectors)
    `CHK("device", 1'b0, mediaDevice)
    nrst <= 1'b0;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rc(`OFS_CONDITION, 32'h40);
    `CHK("int", 1'b0, hostIntLine)
    stopTest;
  end
endmodule
